// [supply_fault_pin_regs.sv]
// supply-fault force/readback register and general-purpose pin level register with pin events
`timescale 1ns/1ps
module supply_fault_pin_regs
	import supply_pin_pkg::*;
#(
	parameter int PIN_COUNT = 13
)
(
	input  wire logic                              clk_i,
	input  wire logic                              rst_n_i,
	input  wire logic [supply_pin_pkg::ADDR_W-1:0] awaddr_i,
	input  wire logic                              awvalid_i,
	output logic                                   awready_o,
	input  wire logic [supply_pin_pkg::DATA_W-1:0] wdata_i,
	input  wire logic [3:0]                        wstrb_i,
	input  wire logic                              wvalid_i,
	output logic                                   wready_o,
	output logic [1:0]                             bresp_o,
	output logic                                   bvalid_o,
	input  wire logic                              bready_i,
	input  wire logic [supply_pin_pkg::ADDR_W-1:0] araddr_i,
	input  wire logic                              arvalid_i,
	output logic                                   arready_o,
	output logic [supply_pin_pkg::DATA_W-1:0]      rdata_o,
	output logic [1:0]                             rresp_o,
	output logic                                   rvalid_o,
	input  wire logic                              rready_i,
	input  wire supply_pin_pkg::fault_sig_s        fault_raw_i,
	output supply_pin_pkg::fault_sig_s             fault_deb_o,
	input  wire logic [PIN_COUNT-1:0]              pin_in_i,
	output logic [PIN_COUNT-1:0]                   pin_out_o,
	output logic [PIN_COUNT-1:0]                   pin_oe_o,
	output logic                                   irq_o
);
	import supply_pin_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// elaboration check: pins must fit below the tied-high top bits

	generate
		if (PIN_COUNT < 1 || PIN_COUNT > MAX_PINS)
		begin : g_bad_pins
			$error("PIN_COUNT must lie between 1 and 13");
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// declarations

	reg_wr_s                wr;
	reg_rd_s                rd;
	logic [REG_W-1:0]       rd_data;
	logic                   rd_err;
	logic                   wr_err;

	logic [1:0]             ctrl_r;
	logic [1:0]             ctrl_nxt;
	logic [REG_W-1:0]       force_r;
	logic [REG_W-1:0]       force_nxt;
	fault_sig_s             deb_r;
	fault_sig_s             deb_nxt;

	logic [PIN_COUNT-1:0]   dir_r;
	logic [PIN_COUNT-1:0]   dir_nxt;
	logic [PIN_COUNT-1:0]   out_r;
	logic [PIN_COUNT-1:0]   out_nxt;
	logic [PIN_COUNT-1:0]   prev_r;
	logic                   primed_r;
	logic [PIN_COUNT-1:0]   flag_r;
	logic [PIN_COUNT-1:0]   flag_nxt;
	logic [PIN_COUNT-1:0]   mask_r;
	logic [PIN_COUNT-1:0]   mask_nxt;

	wire  [REG_W-1:0]       wmask;
	wire  [REG_W-1:0]       wbits;
	wire  [PIN_COUNT-1:0]   wmask_pin;
	wire  [PIN_COUNT-1:0]   wdata_pin;
	wire                    wr_force;
	wire                    wr_level;
	wire                    wr_ctrl;
	wire                    wr_dir;
	wire                    wr_status;
	wire                    wr_mask;
	wire  [PIN_COUNT-1:0]   pin_change;
	wire  [PIN_COUNT-1:0]   clr_level;
	wire  [PIN_COUNT-1:0]   clr_w1c;
	wire  [PIN_COUNT-1:0]   pin_level;
	wire  [REG_W-1:0]       level_word;
	wire  [REG_W-1:0]       raw_word;

	////////////////////////////////////////////////////////////////////////////
	// bus slave

	axil_reg_port u_port
	(
		.clk_i     (clk_i),
		.rst_n_i   (rst_n_i),
		.awaddr_i  (awaddr_i),
		.awvalid_i (awvalid_i),
		.awready_o (awready_o),
		.wdata_i   (wdata_i),
		.wstrb_i   (wstrb_i),
		.wvalid_i  (wvalid_i),
		.wready_o  (wready_o),
		.bresp_o   (bresp_o),
		.bvalid_o  (bvalid_o),
		.bready_i  (bready_i),
		.araddr_i  (araddr_i),
		.arvalid_i (arvalid_i),
		.arready_o (arready_o),
		.rdata_o   (rdata_o),
		.rresp_o   (rresp_o),
		.rvalid_o  (rvalid_o),
		.rready_i  (rready_i),
		.wr_o      (wr),
		.wr_err_i  (wr_err),
		.rd_o      (rd),
		.rd_data_i (rd_data),
		.rd_err_i  (rd_err)
	);

	////////////////////////////////////////////////////////////////////////////
	// write decode; unmapped indexes store nothing and answer with an error

	assign wr_err    = !idx_mapped(wr.idx);
	assign rd_err    = !idx_mapped(rd.idx);
	assign wmask     = strb_mask(wr.strb);
	assign wbits     = wr.data & wmask;
	assign wmask_pin = wmask[PIN_COUNT-1:0];
	assign wdata_pin = wr.data[PIN_COUNT-1:0];
	assign wr_force  = wr.en && (wr.idx == IDX_FAULT_FORCE);
	assign wr_level  = wr.en && (wr.idx == IDX_PIN_LEVEL);
	assign wr_ctrl   = wr.en && (wr.idx == IDX_FORCE_CTRL);
	assign wr_dir    = wr.en && (wr.idx == IDX_PIN_DIR);
	assign wr_status = wr.en && (wr.idx == IDX_IRQ_STATUS);
	assign wr_mask   = wr.en && (wr.idx == IDX_IRQ_MASK);

	////////////////////////////////////////////////////////////////////////////
	// supply-fault force path

	// only the documented force fields hold a value; the gaps stay zero
	assign force_nxt = wr_force ? (((force_r & ~wmask) | wbits) & FORCE_FIELDS) : force_r;
	assign ctrl_nxt  = wr_ctrl ? ((ctrl_r & ~wmask[1:0]) | wbits[1:0]) : ctrl_r;

	// debounce inputs: forced value only while its enable is set, raw comparator otherwise
	assign deb_nxt.oc_ls   = ctrl_r[CTRL_OC_EN] ? force_r[FLD_OC_LS] : fault_raw_i.oc_ls;
	assign deb_nxt.ldo_uv  = ctrl_r[CTRL_UV_EN] ? force_r[FLD_LDO_LSB +: NUM_LDO]
		: fault_raw_i.ldo_uv;
	assign deb_nxt.buck_uv = ctrl_r[CTRL_UV_EN] ? force_r[FLD_BUCK_LSB +: NUM_BUCK]
		: fault_raw_i.buck_uv;

	// readback shows the comparators, never the forced value
	assign raw_word = fault_word(fault_raw_i);

	// force value and enables
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			force_r <= RST_FORCE;
			ctrl_r  <= RST_CTRL;
		end
		else
		begin
			force_r <= force_nxt;
			ctrl_r  <= ctrl_nxt;
		end
	end

	// the mux is registered so the debounce stage sees a clean level; the fault
	// responses stay behind it, so a forced fault is still filtered as a real one
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
			deb_r <= '0;
		else
			deb_r <= deb_nxt;
	end

	assign fault_deb_o = deb_r;

	////////////////////////////////////////////////////////////////////////////
	// pin direction and driven levels

	// direction 1 = output; a write to the level register sets the driven level of output pins only
	assign dir_nxt = wr_dir ? ((dir_r & ~wmask_pin) | (wdata_pin & wmask_pin)) : dir_r;
	assign out_nxt = wr_level ? ((out_r & ~(wmask_pin & dir_r)) | (wdata_pin & wmask_pin & dir_r))
		: out_r;

	// direction and output latches reset to zero
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			dir_r <= RST_PINS[PIN_COUNT-1:0];
			out_r <= RST_PINS[PIN_COUNT-1:0];
		end
		else
		begin
			dir_r <= dir_nxt;
			out_r <= out_nxt;
		end
	end

	assign pin_out_o = out_r;
	assign pin_oe_o  = dir_r;

	// inputs read the pin itself, outputs read back what is driven
	assign pin_level  = (dir_r & out_r) | (~dir_r & pin_in_i);
	assign level_word = PIN_RSVD_MASK | REG_W'(pin_level);

	////////////////////////////////////////////////////////////////////////////
	// pin events and interrupt

	// an event is any level change on an input pin; the first sample after reset
	// only primes the history, so a pin already high raises no false event
	assign pin_change = primed_r ? ((pin_in_i ^ prev_r) & ~dir_r) : '0;

	// clears: a zero written to an input pin's level bit, or a one to its status bit
	assign clr_level = wr_level ? (wmask_pin & ~wdata_pin & ~dir_r) : '0;
	assign clr_w1c   = wr_status ? (wmask_pin & wdata_pin) : '0;

	// a change in the clearing cycle wins, so no event is lost
	assign flag_nxt = pin_change | (flag_r & ~(clr_level | clr_w1c));
	assign mask_nxt = wr_mask ? ((mask_r & ~wmask_pin) | (wdata_pin & wmask_pin)) : mask_r;

	// pin history
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			prev_r   <= '0;
			primed_r <= 1'b0;
		end
		else
		begin
			prev_r   <= pin_in_i;
			primed_r <= 1'b1;
		end
	end

	// sticky event flags and their mask
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			flag_r <= '0;
			mask_r <= '0;
		end
		else
		begin
			flag_r <= flag_nxt;
			mask_r <= mask_nxt;
		end
	end

	// level interrupt while any unmasked flag stands
	assign irq_o = |(flag_r & mask_r);

	////////////////////////////////////////////////////////////////////////////
	// read mux; reads have no side effects, unmapped reads return zero

	assign rd_data =
		(rd.idx == IDX_FAULT_FORCE) ? raw_word :
		(rd.idx == IDX_PIN_LEVEL)   ? level_word :
		(rd.idx == IDX_FORCE_CTRL)  ? REG_W'(ctrl_r) :
		(rd.idx == IDX_PIN_DIR)     ? REG_W'(dir_r) :
		(rd.idx == IDX_IRQ_STATUS)  ? REG_W'(flag_r) :
		(rd.idx == IDX_IRQ_MASK)    ? REG_W'(mask_r) :
		16'h0000;

endmodule : supply_fault_pin_regs

// [supply_pin_pkg.sv]
// shared constants, types and helpers for the supply-fault and pin-level register bank
package supply_pin_pkg;

	// bus geometry: register index is the byte address divided by four
	localparam int ADDR_W = 10;
	localparam int DATA_W = 32;
	localparam int REG_W  = 16;

	// register indexes (byte address = 4 * index)
	localparam logic [7:0] IDX_FAULT_FORCE = 8'he5;
	localparam logic [7:0] IDX_PIN_LEVEL   = 8'he6;
	localparam logic [7:0] IDX_FORCE_CTRL  = 8'hf0;
	localparam logic [7:0] IDX_PIN_DIR     = 8'hf1;
	localparam logic [7:0] IDX_IRQ_STATUS  = 8'hf2;
	localparam logic [7:0] IDX_IRQ_MASK    = 8'hf3;

	// field positions of the supply-fault force register
	localparam int FLD_OC_LS    = 15;
	localparam int FLD_LDO_LSB  = 8;
	localparam int FLD_BUCK_LSB = 0;
	localparam int NUM_LDO      = 4;
	localparam int NUM_BUCK     = 6;
	localparam logic [15:0] FORCE_FIELDS = 16'h8f3f;

	// field positions of the force control register
	localparam int CTRL_OC_EN = 0;
	localparam int CTRL_UV_EN = 1;

	// pin level register: pins sit in the low bits, the top three bits are tied high
	localparam int          MAX_PINS      = 13;
	localparam logic [15:0] PIN_RSVD_MASK = 16'he000;

	// reset values
	localparam logic [15:0] RST_FORCE = 16'h0000;
	localparam logic [1:0]  RST_CTRL  = 2'h0;
	localparam logic [15:0] RST_PINS  = 16'h0000;

	// bus answers
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// raw or debounce-side supply fault signals
	typedef struct packed {
		logic                oc_ls;
		logic [NUM_LDO-1:0]  ldo_uv;
		logic [NUM_BUCK-1:0] buck_uv;
	} fault_sig_s;

	// one register write, valid for the cycle en is high
	typedef struct packed {
		logic             en;
		logic [7:0]       idx;
		logic [REG_W-1:0] data;
		logic [1:0]       strb;
	} reg_wr_s;

	// one register read, valid for the cycle en is high
	typedef struct packed {
		logic       en;
		logic [7:0] idx;
	} reg_rd_s;

	// write-side handshake states of the bus slave
	typedef enum logic [1:0] {
		WR_IDLE      = 2'b00,
		WR_HAVE_ADDR = 2'b01,
		WR_HAVE_DATA = 2'b10,
		WR_RESP      = 2'b11
	} wr_state_e;

	// place fault signals at their register bit positions
	function automatic logic [15:0] fault_word(input fault_sig_s f);
		logic [15:0] w;
		w = 16'h0000;
		w[FLD_OC_LS] = f.oc_ls;
		w[FLD_LDO_LSB +: NUM_LDO] = f.ldo_uv;
		w[FLD_BUCK_LSB +: NUM_BUCK] = f.buck_uv;
		return w;
	endfunction : fault_word

	// expand byte strobes into a bit mask of the low register half-words
	function automatic logic [15:0] strb_mask(input logic [1:0] s);
		return {{8{s[1]}}, {8{s[0]}}};
	endfunction : strb_mask

	// true for every index that holds a register
	function automatic logic idx_mapped(input logic [7:0] i);
		return (i == IDX_FAULT_FORCE) || (i == IDX_PIN_LEVEL) || (i == IDX_FORCE_CTRL)
			|| (i == IDX_PIN_DIR) || (i == IDX_IRQ_STATUS) || (i == IDX_IRQ_MASK);
	endfunction : idx_mapped

endpackage : supply_pin_pkg

// [axil_reg_port.sv]
// axi4-lite slave front end turning bus transfers into register write and read strobes
`timescale 1ns/1ps
module axil_reg_port
	import supply_pin_pkg::*;
(
	input  wire logic                          clk_i,
	input  wire logic                          rst_n_i,
	input  wire logic [supply_pin_pkg::ADDR_W-1:0] awaddr_i,
	input  wire logic                          awvalid_i,
	output logic                               awready_o,
	input  wire logic [supply_pin_pkg::DATA_W-1:0] wdata_i,
	input  wire logic [3:0]                    wstrb_i,
	input  wire logic                          wvalid_i,
	output logic                               wready_o,
	output logic [1:0]                         bresp_o,
	output logic                               bvalid_o,
	input  wire logic                          bready_i,
	input  wire logic [supply_pin_pkg::ADDR_W-1:0] araddr_i,
	input  wire logic                          arvalid_i,
	output logic                               arready_o,
	output logic [supply_pin_pkg::DATA_W-1:0]  rdata_o,
	output logic [1:0]                         rresp_o,
	output logic                               rvalid_o,
	input  wire logic                          rready_i,
	output supply_pin_pkg::reg_wr_s            wr_o,
	input  wire logic                          wr_err_i,
	output supply_pin_pkg::reg_rd_s            rd_o,
	input  wire logic [supply_pin_pkg::REG_W-1:0] rd_data_i,
	input  wire logic                          rd_err_i
);
	import supply_pin_pkg::*;

	wr_state_e                  state_r;
	wr_state_e                  state_nxt;
	logic [ADDR_W-1:0]          awaddr_r;
	logic [REG_W-1:0]           wdata_r;
	logic [1:0]                 wstrb_r;
	logic [1:0]                 bresp_r;
	logic                       rvalid_r;
	logic [DATA_W-1:0]          rdata_r;
	logic [1:0]                 rresp_r;
	wire                        aw_hs;
	wire                        w_hs;
	wire                        ar_hs;
	wire                        have_aw;
	wire                        have_w;

	////////////////////////////////////////////////////////////////////////////
	// write channels: address and data accepted in either order, held until both are in
	assign awready_o = (state_r == WR_IDLE) || (state_r == WR_HAVE_DATA);
	assign wready_o  = (state_r == WR_IDLE) || (state_r == WR_HAVE_ADDR);
	assign aw_hs     = awvalid_i && awready_o;
	assign w_hs      = wvalid_i && wready_o;
	assign have_aw   = aw_hs || (state_r == WR_HAVE_ADDR);
	assign have_w    = w_hs || (state_r == WR_HAVE_DATA);
	assign wr_o.en   = have_aw && have_w;
	assign wr_o.idx  = (state_r == WR_HAVE_ADDR) ? awaddr_r[ADDR_W-1:2] : awaddr_i[ADDR_W-1:2];
	assign wr_o.data = (state_r == WR_HAVE_DATA) ? wdata_r : wdata_i[REG_W-1:0];
	assign wr_o.strb = (state_r == WR_HAVE_DATA) ? wstrb_r : wstrb_i[1:0];
	assign bvalid_o  = (state_r == WR_RESP);
	assign bresp_o   = bresp_r;

	// next write state
	always_comb
	begin
		state_nxt = state_r;
		case (state_r)
			WR_IDLE:
			begin
				if (aw_hs && w_hs)
					state_nxt = WR_RESP;
				else if (aw_hs)
					state_nxt = WR_HAVE_ADDR;
				else if (w_hs)
					state_nxt = WR_HAVE_DATA;
			end
			WR_HAVE_ADDR: if (w_hs) state_nxt = WR_RESP;
			WR_HAVE_DATA: if (aw_hs) state_nxt = WR_RESP;
			WR_RESP:      if (bready_i) state_nxt = WR_IDLE;
			default:      state_nxt = WR_IDLE;
		endcase
	end

	// write state and captured halves of a split transfer
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			state_r  <= WR_IDLE;
			awaddr_r <= '0;
			wdata_r  <= '0;
			wstrb_r  <= 2'h0;
			bresp_r  <= RESP_OKAY;
		end
		else
		begin
			state_r <= state_nxt;
			if (aw_hs)
				awaddr_r <= awaddr_i;
			if (w_hs)
			begin
				wdata_r <= wdata_i[REG_W-1:0];
				wstrb_r <= wstrb_i[1:0];
			end
			if (wr_o.en)
				bresp_r <= wr_err_i ? RESP_SLVERR : RESP_OKAY;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// read channel: data registered one cycle after the address is taken
	assign arready_o = !rvalid_r;
	assign ar_hs     = arvalid_i && arready_o;
	assign rd_o.en   = ar_hs;
	assign rd_o.idx  = araddr_i[ADDR_W-1:2];
	assign rvalid_o  = rvalid_r;
	assign rdata_o   = rdata_r;
	assign rresp_o   = rresp_r;

	// read answer holds until the master takes it
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			rvalid_r <= 1'b0;
			rdata_r  <= '0;
			rresp_r  <= RESP_OKAY;
		end
		else if (ar_hs)
		begin
			rvalid_r <= 1'b1;
			rdata_r  <= DATA_W'(rd_data_i);
			rresp_r  <= rd_err_i ? RESP_SLVERR : RESP_OKAY;
		end
		else if (rready_i)
			rvalid_r <= 1'b0;
	end

endmodule : axil_reg_port

// [supply_fault_pin_props.sv]
// assertion checker for the supply-fault and pin-level register bank
`timescale 1ns/1ps
module supply_fault_pin_props
	import supply_pin_pkg::*;
#(
	parameter int PIN_COUNT = 13
)
(
	input wire logic                                 clk_i,
	input wire logic                                 rst_n_i,
	input wire logic                                 awvalid_i,
	input wire logic                                 awready_o,
	input wire logic                                 wvalid_i,
	input wire logic                                 wready_o,
	input wire logic                                 bvalid_o,
	input wire logic                                 bready_i,
	input wire logic [supply_pin_pkg::ADDR_W-1:0]    araddr_i,
	input wire logic                                 arvalid_i,
	input wire logic                                 arready_o,
	input wire logic [supply_pin_pkg::DATA_W-1:0]    rdata_o,
	input wire logic [1:0]                           rresp_o,
	input wire logic                                 rvalid_o,
	input wire logic                                 rready_i,
	input wire supply_pin_pkg::fault_sig_s           fault_deb_o,
	input wire logic [PIN_COUNT-1:0]                 pin_out_o,
	input wire logic [PIN_COUNT-1:0]                 pin_oe_o,
	input wire logic                                 irq_o
);
	logic [7:0] rd_idx_r;

	////////////////////////////////////////////////////////////////////////////////
	// remember which register the pending read targets
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
			rd_idx_r <= 8'h00;
		else if (arvalid_i && arready_o)
			rd_idx_r <= araddr_i[9:2];
	end

	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	////////////////////////////////////////////////////////////////////////////////
	// bus answers come one cycle after the request is taken and leave after the handshake
	a_write_answer: assert property (awvalid_i && awready_o && wvalid_i && wready_o |=> bvalid_o)
		else $error("write response missing");
	a_write_done: assert property (bvalid_o && bready_i |=> !bvalid_o)
		else $error("write response not retired");
	a_read_answer: assert property (arvalid_i && arready_o |=> rvalid_o)
		else $error("read data missing");
	a_read_done: assert property (rvalid_o && rready_i |=> !rvalid_o)
		else $error("read data not retired");
	a_read_block: assert property (rvalid_o |-> !arready_o)
		else $error("read taken while data pending");
	a_rdata_upper: assert property (rvalid_o |-> rdata_o[31:16] == 16'h0000)
		else $error("upper read half not zero");
	a_unmapped_zero: assert property (rvalid_o && rresp_o == RESP_SLVERR |-> rdata_o == '0)
		else $error("error read returned data");
	// top three pin-level bits are tied high in every read
	a_rsvd_ones: assert property (rvalid_o && rd_idx_r == IDX_PIN_LEVEL |-> rdata_o[15:13] == 3'b111)
		else $error("unused pin bits not one");
	// reset must be seen even though the other checks are disabled by it
	a_reset_quiet: assert property (disable iff (1'b0) !rst_n_i |=>
		pin_out_o == '0 && pin_oe_o == '0 && !irq_o && fault_deb_o == '0)
		else $error("outputs not cleared by reset");
endmodule : supply_fault_pin_props

bind supply_fault_pin_regs supply_fault_pin_props #(.PIN_COUNT(PIN_COUNT)) props_i (.clk_i, .rst_n_i,
	.awvalid_i, .awready_o, .wvalid_i, .wready_o, .bvalid_o, .bready_i, .araddr_i, .arvalid_i,
	.arready_o, .rdata_o, .rresp_o, .rvalid_o, .rready_i, .fault_deb_o, .pin_out_o, .pin_oe_o, .irq_o);

// [tb.sv]
// self-checking bench for the supply-fault and pin-level register bank
`timescale 1ns/1ps
module tb;
	import supply_pin_pkg::*;

	typedef struct {
		logic [9:0]  a;
		logic [15:0] d;
		bit          w;
		logic [31:0] e;
		logic [1:0]  r;
	} row_s;

	logic        clk_i     = 1'b0;
	logic        rst_n_i   = 1'b0;
	logic [9:0]  awaddr_i  = 10'h000;
	logic        awvalid_i = 1'b0;
	logic [31:0] wdata_i   = 32'h00000000;
	logic [3:0]  wstrb_i   = 4'h0;
	logic        wvalid_i  = 1'b0;
	logic        bready_i  = 1'b0;
	logic [9:0]  araddr_i  = 10'h000;
	logic        arvalid_i = 1'b0;
	logic        rready_i  = 1'b0;
	fault_sig_s  fault_raw_i = '{oc_ls: 1'b0, ldo_uv: 4'h5, buck_uv: 6'h2a};
	logic [12:0] pin_in_i  = 13'h0000;
	logic        awready_o, wready_o, bvalid_o, arready_o, rvalid_o, irq_o;
	logic [1:0]  bresp_o, rresp_o;
	logic [31:0] rdata_o;
	fault_sig_s  fault_deb_o;
	logic [12:0] pin_out_o, pin_oe_o;
	int          err_count = 0;
	int          total_checks = 0;
	// plain register reads, writes and two unmapped places
	row_s        rows [8] = '{
		'{10'h394, 16'h0000, 1'b0, 32'h0000052a, RESP_OKAY},
		'{10'h398, 16'h0000, 1'b0, 32'h0000e000, RESP_OKAY},
		'{10'h3c0, 16'h0000, 1'b0, 32'h00000000, RESP_OKAY},
		'{10'h3c8, 16'h0000, 1'b0, 32'h00000000, RESP_OKAY},
		'{10'h3c4, 16'h0010, 1'b1, 32'h00000010, RESP_OKAY},
		'{10'h3cc, 16'h0008, 1'b1, 32'h00000008, RESP_OKAY},
		'{10'h000, 16'h1234, 1'b1, 32'h00000000, RESP_SLVERR},
		'{10'h3fc, 16'h0000, 1'b0, 32'h00000000, RESP_SLVERR}};

	////////////////////////////////////////////////////////////////////////////////
	// 125 MHz clock and the design
	always #4 clk_i = ~clk_i;

	supply_fault_pin_regs #(.PIN_COUNT(13)) DUT (.clk_i, .rst_n_i, .awaddr_i, .awvalid_i, .awready_o,
		.wdata_i, .wstrb_i, .wvalid_i, .wready_o, .bresp_o, .bvalid_o, .bready_i, .araddr_i, .arvalid_i,
		.arready_o, .rdata_o, .rresp_o, .rvalid_o, .rready_i, .fault_raw_i, .fault_deb_o, .pin_in_i,
		.pin_out_o, .pin_oe_o, .irq_o);

	////////////////////////////////////////////////////////////////////////////////
	// comparison and bus tasks; each bus task waits an edge first so no signal is driven twice a step
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			err_count++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
	endtask : tick

	task automatic wr(input logic [9:0] a, input logic [15:0] d, input logic [1:0] er);
		int n;
		n = 0;
		@(posedge clk_i);
		awaddr_i <= a;
		awvalid_i <= 1'b1;
		wdata_i <= {16'h0000, d};
		wstrb_i <= 4'h3;
		wvalid_i <= 1'b1;
		bready_i <= 1'b1;
		do
		begin
			@(posedge clk_i);
			if (awready_o && awvalid_i) awvalid_i <= 1'b0;
			if (wready_o && wvalid_i) wvalid_i <= 1'b0;
			n++;
		end
		while (!bvalid_o && n < 50);
		// a response that never came counts as a mismatch
		chk("bvalid", 32'(bvalid_o), 32'h1);
		chk("bresp", 32'(bresp_o), 32'(er));
		bready_i <= 1'b0;
	endtask : wr

	task automatic rdc(input logic [9:0] a, input logic [31:0] e, input logic [1:0] er);
		int n;
		n = 0;
		@(posedge clk_i);
		araddr_i <= a;
		arvalid_i <= 1'b1;
		rready_i <= 1'b1;
		do
		begin
			@(posedge clk_i);
			if (arready_o && arvalid_i) arvalid_i <= 1'b0;
			n++;
		end
		while (!rvalid_o && n < 50);
		// read data that never came counts as a mismatch
		chk("rvalid", 32'(rvalid_o), 32'h1);
		chk("rdata", rdata_o, e);
		chk("rresp", 32'(rresp_o), 32'(er));
		rready_i <= 1'b0;
	endtask : rdc

	task automatic stop_test;
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : stop_test

	////////////////////////////////////////////////////////////////////////////////
	// watchdog: the whole sequence needs well under a thousand cycles
	initial
	begin
		repeat (3000) @(posedge clk_i);
		err_count++;
		$display("watchdog expired");
		stop_test();
	end

	////////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial
	begin
		repeat (3) @(posedge clk_i);
		rst_n_i <= 1'b1;
		tick(2);
		chk("pin_out", 32'(pin_out_o), 32'h0);
		chk("irq", 32'(irq_o), 32'h0);
		chk("deb", 32'(fault_deb_o), 32'(fault_raw_i));
		$display("test reset done");
		foreach (rows[i])
		begin
			if (rows[i].w) wr(rows[i].a, rows[i].d, rows[i].r);
			rdc(rows[i].a, rows[i].e, rows[i].r);
		end
		$display("test table done");
		// forced values reach the debounce side only while their enable is set
		wr(10'h394, 16'h8a15, RESP_OKAY);
		tick(2);
		chk("deb", 32'(fault_deb_o), 32'h16a);
		wr(10'h3c0, 16'h0001, RESP_OKAY);
		tick(2);
		chk("deb", 32'(fault_deb_o), 32'({1'b1, 4'h5, 6'h2a}));
		wr(10'h3c0, 16'h0003, RESP_OKAY);
		tick(2);
		chk("deb", 32'(fault_deb_o), 32'({1'b1, 4'ha, 6'h15}));
		fault_raw_i <= '{oc_ls: 1'b1, ldo_uv: 4'h0, buck_uv: 6'h01};
		tick(2);
		chk("deb", 32'(fault_deb_o), 32'({1'b1, 4'ha, 6'h15}));
		rdc(10'h394, 32'h00008001, RESP_OKAY);
		wr(10'h3c0, 16'h0000, RESP_OKAY);
		tick(2);
		chk("deb", 32'(fault_deb_o), 32'({1'b1, 4'h0, 6'h01}));
		$display("test fault done");
		// pin4 is an output, pin3 an input with its event unmasked
		wr(10'h398, 16'h0010, RESP_OKAY);
		chk("pin_out", 32'(pin_out_o), 32'h0010);
		chk("pin_oe", 32'(pin_oe_o), 32'h0010);
		pin_in_i <= 13'h0008;
		tick(3);
		chk("irq", 32'(irq_o), 32'h1);
		rdc(10'h3c8, 32'h00000008, RESP_OKAY);
		rdc(10'h398, 32'h0000e018, RESP_OKAY);
		wr(10'h398, 16'h0018, RESP_OKAY);
		rdc(10'h3c8, 32'h00000008, RESP_OKAY);
		chk("pin_out", 32'(pin_out_o), 32'h0010);
		wr(10'h398, 16'h0010, RESP_OKAY);
		rdc(10'h3c8, 32'h00000000, RESP_OKAY);
		chk("irq", 32'(irq_o), 32'h0);
		// a change on the output pin raises nothing; the fall on pin3 does
		pin_in_i <= 13'h0018;
		tick(3);
		rdc(10'h3c8, 32'h00000000, RESP_OKAY);
		pin_in_i <= 13'h0010;
		tick(3);
		chk("irq", 32'(irq_o), 32'h1);
		wr(10'h3cc, 16'h0000, RESP_OKAY);
		tick(1);
		chk("irq", 32'(irq_o), 32'h0);
		wr(10'h3c8, 16'h0008, RESP_OKAY);
		rdc(10'h3c8, 32'h00000000, RESP_OKAY);
		$display("test pins done");
		// second reset in mid-run returns every pin to input
		rst_n_i <= 1'b0;
		tick(3);
		rst_n_i <= 1'b1;
		tick(2);
		chk("pin_out", 32'(pin_out_o), 32'h0);
		chk("pin_oe", 32'(pin_oe_o), 32'h0);
		rdc(10'h398, 32'h0000e010, RESP_OKAY);
		rdc(10'h3c0, 32'h00000000, RESP_OKAY);
		$display("test second reset done");
		stop_test();
	end
endmodule : tb
